// ---- hdl/cdl_pkg.sv ----
// shared constants of the channel diagnosis logic
package cdl_pkg;
  localparam int CDL_NUM_CH = 4;
  localparam int CDL_SEL_W = 3;
  localparam int CDL_CNT_W = 2;
  // diagnosis word layout
  localparam int CDL_WORD_W = 8;
  localparam int CDL_ERR_LSB = 0;
  localparam int CDL_ERR_MSB = 3;
  localparam int CDL_BIT_BYPASS = 4;
  localparam int CDL_BIT_STAT5 = 5;
  localparam int CDL_BIT_ZERO = 6;
  localparam int CDL_BIT_STAT7 = 7;
  localparam logic [CDL_WORD_W-1:0] CDL_WORD_RST = 8'h00;
  // serial clock edges counted from the start of a frame
  localparam logic [CDL_CNT_W-1:0] CDL_EDGE_CLEAR = 2'h2;
  localparam logic [CDL_CNT_W-1:0] CDL_EDGE_REARM = 2'h3;
  localparam logic [CDL_CNT_W-1:0] CDL_CNT_RST = 2'h0;
  localparam logic [CDL_CNT_W-1:0] CDL_CNT_ONE = 2'h1;
  // sense-select encodings
  localparam logic [CDL_SEL_W-1:0] CDL_SEL_LAST_INT = 3'h3;
  localparam logic [CDL_SEL_W-1:0] CDL_SEL_EXT0 = 3'h4;
  localparam logic [CDL_SEL_W-1:0] CDL_SEL_EXT1 = 3'h5;
  localparam logic [CDL_SEL_W-1:0] CDL_SEL_OFF = 3'h7;
  localparam logic [CDL_SEL_W-1:0] CDL_SEL_RST = 3'h7;
  // channels that own an over-current latch
  localparam logic [CDL_NUM_CH-1:0] CDL_OC_MASK = 4'h3;
  // channels with a selectable load type
  localparam int CDL_LT_LSB = 2;
  localparam int CDL_LT_W = 2;
  // frame edge tracker state
  typedef enum logic [1:0] {
    CDL_FR_IDLE = 2'b00,
    CDL_FR_HOLD = 2'b01,
    CDL_FR_LIVE = 2'b10
  } cdl_frame_e;
endpackage

// ---- hdl/cdl_sync.sv ----
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module cdl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule

// ---- hdl/cdl_chan.sv ----
// per-channel protection latches and error flag
`timescale 1ns/1ps
module cdl_chan #(
  parameter bit HAS_OC = 1'b1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic on_in,
  input wire logic overtemp_in,
  input wire logic overcurrent_in,
  input wire logic dyn_final_in,
  input wire logic overload_mon_in,
  input wire logic clear_latch_in,
  input wire logic flag_clear_in,
  input wire logic flag_block_in,
  output logic err_out,
  output logic latch_off_out,
  output logic sense_ok_out
);
  logic ot_reg;
  logic oc_reg;
  logic dyn_reg;
  logic flag_reg;
  logic ot_next;
  logic oc_next;
  logic dyn_next;
  logic flag_next;
  logic latched;

  // latches hold until the clear command; a new event in the same cycle wins
  assign ot_next = overtemp_in | (ot_reg & ~clear_latch_in);
  assign oc_next = (HAS_OC & overcurrent_in) | (oc_reg & ~clear_latch_in);
  assign dyn_next = dyn_final_in | (dyn_reg & ~clear_latch_in);
  assign latched = ot_reg | oc_reg | dyn_reg;
  // flag is the or of latches and overload monitor, cleared by the frame
  // and kept from setting until the rearm edge, so a stuck overload
  // shows again right after the window
  assign flag_next = flag_block_in ? 1'b0 :
                     ((latched | overload_mon_in) | (flag_reg & ~flag_clear_in));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ot_reg <= 1'b0;
      oc_reg <= 1'b0;
      dyn_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      ot_reg <= ot_next;
      oc_reg <= oc_next;
      dyn_reg <= dyn_next;
      flag_reg <= flag_next;
    end
  end

  assign err_out = flag_reg & on_in;
  assign latch_off_out = latched;
  assign sense_ok_out = on_in & ~latched & ~overload_mon_in
                        & ~overcurrent_in & ~overtemp_in;
endmodule

// ---- hdl/cdl_top.sv ----
// channel diagnosis logic: fault flags, diagnosis word, sense mux, bypass monitor
// What this block does
// - return eight-bit word: channel errors low, bypass bit 4, bit 6 zero
// - channel error is or of over-temperature, over-current and final dynamic latches and latched overload
// - overload part held until sent, cleared between second and third edge
// - over-temperature, and over-current on channels 0/1, latch channel off
// - after clear-latch, flag clears next frame, rearms after third edge
// - persisting overload sets the flag again right after clearing
// - on-state shutdowns set error and kill sense; off-state error reads 0
// - sense off when off, over-current, dynamic shutdown or over-temperature
// - overload flags clear with each word sent
// - over-temperature, over-current, final dynamic latch clear only by command
// - channels 2 and 3 pick LED or bulb sense ratio by load-type bit
// - sense multiplexer routes at most one selected channel to sense pin
// - two sense-select settings, six and seven, disable the sense output entirely
// - sense-select drives external diagnosis enable; compat bit remaps pins
// - bypass monitor compares selected channel, result in register and word
// - bypass result 1 healthy off, 0 shorted to supply, 0 when on
// - off-state source on selected channel when enabled; level bit chooses current
// - open load gives 0 only with channel 0-3 selected and source enabled
// - writing 1 to clear-latch clears all latches; writing 0 does nothing
`timescale 1ns/1ps
module cdl_top
  import cdl_pkg::*;
#(
  parameter int NUM_CH = cdl_pkg::CDL_NUM_CH
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic SCLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] CHANNEL_ON_CMD_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] OVERTEMP_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] OVERCURRENT_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] DYN_FINAL_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] OVERLOAD_MON_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] VDS_ABOVE_THR_IN,
  input wire logic CLEAR_LATCH_WR_IN,
  input wire logic CLEAR_LATCH_CMD_IN,
  input wire logic [cdl_pkg::CDL_LT_W-1:0] LOAD_TYPE_SELECT_IN,
  input wire logic [cdl_pkg::CDL_SEL_W-1:0] SENSE_SELECT_IN,
  input wire logic OFFSTATE_SOURCE_ENABLE_IN,
  input wire logic SOURCE_LEVEL_SELECT_IN,
  input wire logic EXT_DRIVER_COMPAT_BIT_IN,
  input wire logic STATUS_BIT5_IN,
  input wire logic STATUS_BIT7_IN,
  output logic [cdl_pkg::CDL_WORD_W-1:0] CHANNEL_FAULT_SUMMARY_OUT,
  output logic BYPASS_MONITOR_RESULT_OUT,
  output logic [cdl_pkg::CDL_NUM_CH-1:0] SENSE_ROUTE_OUT,
  output logic [cdl_pkg::CDL_NUM_CH-1:0] LATCH_OFF_OUT,
  output logic [cdl_pkg::CDL_NUM_CH-1:0] SOURCE_ENABLE_OUT,
  output logic SOURCE_LEVEL_HIGH_OUT,
  output logic [cdl_pkg::CDL_LT_W-1:0] LED_RATIO_OUT,
  output logic EXT_DIAG_PIN0_OUT,
  output logic EXT_DIAG_PIN1_OUT
);

  // the logic is written for the four channels of the word layout
  // one error bit per channel fills the word's low
  // nibble, so other channel counts are refused
  if (NUM_CH != CDL_NUM_CH) begin : g_bad_ch
    $error("cdl_top supports exactly four channels");
  end

  // ---------------- link side, on the serial clock ----------------
  // a frame: select low, then three or more rises
  // edge one counts, edge two opens the clear window,
  // edge three closes it; later edges change nothing
  // select clears the counter, so a cut frame leaves
  // no residue for the next one
  // limitation: the serial clock must stand low while
  // select falls, or a glitch could count as an edge
  logic [CDL_CNT_W-1:0] edge_cnt_reg;
  logic [CDL_CNT_W-1:0] edge_cnt_next;
  logic clear_tgl_reg;
  logic clear_tgl_next;
  logic rearm_tgl_reg;
  logic rearm_tgl_next;
  logic frame_rst_n;

  // an idle chip select holds the edge counter at zero, so the counter
  // never relies on a serial clock edge outside a frame
  assign frame_rst_n = NRST_IN & ~SPI_CS_N_IN;
  assign edge_cnt_next = (edge_cnt_reg == CDL_EDGE_REARM) ? edge_cnt_reg :
                         edge_cnt_reg + CDL_CNT_ONE;

  // count rising edges of the frame, saturating at the rearm edge
  // saturating keeps edge three the last event even
  // in long frames that carry a whole command word
  always_ff @(posedge SCLK_IN or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      edge_cnt_reg <= CDL_CNT_RST;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // one toggle per event keeps both edge events alive across the crossing
  assign clear_tgl_next = clear_tgl_reg ^ (edge_cnt_next == CDL_EDGE_CLEAR
                          && edge_cnt_reg != CDL_EDGE_CLEAR);
  assign rearm_tgl_next = rearm_tgl_reg ^ (edge_cnt_next == CDL_EDGE_REARM
                          && edge_cnt_reg != CDL_EDGE_REARM);

  // toggles survive chip select; only the chip reset clears them
  // clearing them on select would look like one more
  // toggle to the system side and fake an event
  always_ff @(posedge SCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      clear_tgl_reg <= 1'b0;
      rearm_tgl_reg <= 1'b0;
    end else begin
      clear_tgl_reg <= clear_tgl_next;
      rearm_tgl_reg <= rearm_tgl_next;
    end
  end

  // ---------------- crossings into the system clock ----------------
  // toggles, not pulses: the serial clock may be
  // slower or faster, and a level change is never lost
  // causes are taken as levels; a glitch shorter than
  // a system cycle may be missed, so the analog side
  // must hold its causes longer than that
  // the word reacts three to four cycles after an edge
  localparam int SYNC_W = 2 + 5 * CDL_NUM_CH;
  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic clear_tgl_s;
  logic rearm_tgl_s;
  logic [CDL_NUM_CH-1:0] ot_s;
  logic [CDL_NUM_CH-1:0] oc_s;
  logic [CDL_NUM_CH-1:0] dyn_s;
  logic [CDL_NUM_CH-1:0] ovl_s;
  logic [CDL_NUM_CH-1:0] vds_s;

  // analog comparators and link toggles all arrive asynchronously
  assign sync_d = {clear_tgl_reg, rearm_tgl_reg, OVERTEMP_IN, OVERCURRENT_IN,
                   DYN_FINAL_IN, OVERLOAD_MON_IN, VDS_ABOVE_THR_IN};
  assign {clear_tgl_s, rearm_tgl_s, ot_s, oc_s, dyn_s, ovl_s, vds_s} = sync_q;

  cdl_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_in(SYS_CLK_IN),
    .nrst_in(NRST_IN),
    .d_in(sync_d),
    .q_out(sync_q)
  );

  // ---------------- frame window on the system clock ----------------
  // tracked on the system clock so flags, latches and
  // the clear command all live in one domain
  // idle: nothing pending; hold: flags forced low;
  // live: one cycle in which standing causes set again
  // a clear edge in the live cycle goes straight back
  // to hold, so close frames never skip a window
  cdl_frame_e fr_state_reg;
  cdl_frame_e fr_state_next;
  logic clear_seen_reg;
  logic rearm_seen_reg;
  logic clear_evt;
  logic rearm_evt;
  logic flag_block;

  // edge of a synchronised toggle marks one serial clock event
  assign clear_evt = clear_tgl_s ^ clear_seen_reg;
  assign rearm_evt = rearm_tgl_s ^ rearm_seen_reg;

  // remember the last toggle level seen
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      clear_seen_reg <= 1'b0;
      rearm_seen_reg <= 1'b0;
    end else begin
      clear_seen_reg <= clear_tgl_s;
      rearm_seen_reg <= rearm_tgl_s;
    end
  end

  // window between the clearing edge and the rearm edge of each frame
  always_comb begin
    fr_state_next = fr_state_reg;
    case (fr_state_reg)
      CDL_FR_IDLE: begin
        if (clear_evt) begin
          fr_state_next = CDL_FR_HOLD;
        end
      end
      CDL_FR_HOLD: begin
        if (rearm_evt) begin
          fr_state_next = CDL_FR_LIVE;
        end
      end
      CDL_FR_LIVE: begin
        fr_state_next = clear_evt ? CDL_FR_HOLD : CDL_FR_IDLE;
      end
      default: begin
        fr_state_next = CDL_FR_IDLE;
      end
    endcase
  end

  // a frame shorter than three edges never rearms; the next one does
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fr_state_reg <= CDL_FR_IDLE;
    end else begin
      fr_state_reg <= fr_state_next;
    end
  end

  // flags may not set while the window is open
  // the rearm event itself lifts the block, so a flag
  // can set in the cycle the tracker leaves hold
  assign flag_block = (fr_state_reg == CDL_FR_HOLD) && !rearm_evt;

  // ---------------- per-channel latches and flags ----------------
  // latch and flag are kept apart: the latch turns the
  // channel off, the flag only reports, each with its
  // own clear; after a clear command the flag shows the
  // old fault until the next frame's clear edge arrives
  logic clear_latch;
  logic [CDL_NUM_CH-1:0] err_flag;
  logic [CDL_NUM_CH-1:0] latch_off;
  logic [CDL_NUM_CH-1:0] sense_ok;

  // only a write carrying a one clears the latches
  // a write of zero lets the host touch the other
  // bits of that register without clearing anything
  assign clear_latch = CLEAR_LATCH_WR_IN & CLEAR_LATCH_CMD_IN;

  for (genvar ch = 0; ch < CDL_NUM_CH; ch++) begin : g_chan
    cdl_chan #(
      .HAS_OC(CDL_OC_MASK[ch])
    ) u_chan (
      .clk_in(SYS_CLK_IN),
      .nrst_in(NRST_IN),
      .on_in(CHANNEL_ON_CMD_IN[ch]),
      .overtemp_in(ot_s[ch]),
      .overcurrent_in(oc_s[ch]),
      .dyn_final_in(dyn_s[ch]),
      .overload_mon_in(ovl_s[ch]),
      .clear_latch_in(clear_latch),
      .flag_clear_in(clear_evt),
      .flag_block_in(flag_block),
      .err_out(err_flag[ch]),
      .latch_off_out(latch_off[ch]),
      .sense_ok_out(sense_ok[ch])
    );
  end

  // ---------------- sense multiplexer and external drivers ----------------
  logic sel_internal;
  logic sel_ext0;
  logic sel_ext1;
  logic sel_ext;
  logic [CDL_NUM_CH-1:0] sel_onehot;
  logic [CDL_NUM_CH-1:0] route_next;
  logic [CDL_NUM_CH-1:0] source_next;
  logic pin0_next;
  logic pin1_next;

  // codes six and seven both leave the pin dark, so
  // no stray channel shows on an unused code
  // the disable code and the external codes route no internal channel
  assign sel_internal = (SENSE_SELECT_IN <= CDL_SEL_LAST_INT);
  assign sel_ext0 = (SENSE_SELECT_IN == CDL_SEL_EXT0);
  assign sel_ext1 = (SENSE_SELECT_IN == CDL_SEL_EXT1);
  assign sel_ext = sel_ext0 | sel_ext1;

  // decoder: at most one bit of the one-hot select is ever set
  for (genvar ch = 0; ch < CDL_NUM_CH; ch++) begin : g_sel
    assign sel_onehot[ch] = sel_internal
                            && (SENSE_SELECT_IN[CDL_CNT_W-1:0] == CDL_CNT_W'(ch));
  end

  // a faulted or switched-off channel never reaches the sense pin
  assign route_next = sel_onehot & sense_ok;
  // the source only ever sits on an off channel that is selected
  assign source_next = sel_onehot & ~CHANNEL_ON_CMD_IN
                       & {CDL_NUM_CH{OFFSTATE_SOURCE_ENABLE_IN}};

  // compatibility mode turns the pins into enable and select; otherwise
  // each pin enables the diagnosis of its own external driver
  assign pin0_next = EXT_DRIVER_COMPAT_BIT_IN ? sel_ext : sel_ext0;
  assign pin1_next = EXT_DRIVER_COMPAT_BIT_IN ? sel_ext1 : sel_ext1;

  // ---------------- bypass monitor ----------------
  // with no internal channel selected the result is 0,
  // so a stale comparator level never reaches the word
  logic bypass_next;
  logic bypass_raw;

  // comparator of the selected channel; when on, a closed switch has a
  // small drop and reads 0, so no masking is needed for the on-state
  assign bypass_raw = |(sel_onehot & vds_s);
  assign bypass_next = bypass_raw;

  // ---------------- diagnosis word ----------------
  // bit six is forced low, not left at the reset value,
  // so a change to that constant cannot leak into it
  logic [CDL_WORD_W-1:0] word_next;

  always_comb begin
    word_next = CDL_WORD_RST;
    word_next[CDL_ERR_MSB:CDL_ERR_LSB] = err_flag;
    word_next[CDL_BIT_BYPASS] = bypass_next;
    word_next[CDL_BIT_STAT5] = STATUS_BIT5_IN;
    word_next[CDL_BIT_ZERO] = 1'b0;
    word_next[CDL_BIT_STAT7] = STATUS_BIT7_IN;
  end

  // ---------------- registered outputs ----------------
  // one cycle of latency is small against a frame, and
  // the host never sees a half-updated word
  // everything leaving the block comes from a flip-flop so the shifter
  // and the analog stage never see decode glitches
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      CHANNEL_FAULT_SUMMARY_OUT <= CDL_WORD_RST;
      BYPASS_MONITOR_RESULT_OUT <= 1'b0;
      SENSE_ROUTE_OUT <= '0;
      LATCH_OFF_OUT <= '0;
      SOURCE_ENABLE_OUT <= '0;
      SOURCE_LEVEL_HIGH_OUT <= 1'b0;
      LED_RATIO_OUT <= '0;
      EXT_DIAG_PIN0_OUT <= 1'b0;
      EXT_DIAG_PIN1_OUT <= 1'b0;
    end else begin
      CHANNEL_FAULT_SUMMARY_OUT <= word_next;
      BYPASS_MONITOR_RESULT_OUT <= bypass_next;
      SENSE_ROUTE_OUT <= route_next;
      LATCH_OFF_OUT <= latch_off;
      SOURCE_ENABLE_OUT <= source_next;
      SOURCE_LEVEL_HIGH_OUT <= SOURCE_LEVEL_SELECT_IN;
      LED_RATIO_OUT <= LOAD_TYPE_SELECT_IN;
      EXT_DIAG_PIN0_OUT <= pin0_next;
      EXT_DIAG_PIN1_OUT <= pin1_next;
    end
  end

endmodule

// ---- tb/cdl_spi_master.sv ----
// link master model: frames of serial clock edges framed by an active-low select
`timescale 1ns/1ps
module cdl_spi_master (
  output logic sclk_out,
  output logic cs_n_out
);
  // the serial clock stands low and select stays high outside frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // one whole frame at a 30 ns period; the odd lead-in keeps it out of phase with the system clock
  task automatic send_frame(input int edges);
    #7.3 cs_n_out = 1'b0;
    repeat (edges) begin
      #15 sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
    end
    #15 cs_n_out = 1'b1;
    #30;
  endtask
endmodule

// ---- tb/cdl_props.sv ----
// port-level assertions for the channel diagnosis logic
`timescale 1ns/1ps
module cdl_props
  import cdl_pkg::*;
#(
  parameter int NUM_CH = cdl_pkg::CDL_NUM_CH
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] CHANNEL_ON_CMD_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] OVERTEMP_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] OVERCURRENT_IN,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] DYN_FINAL_IN,
  input wire logic CLEAR_LATCH_WR_IN,
  input wire logic CLEAR_LATCH_CMD_IN,
  input wire logic [cdl_pkg::CDL_SEL_W-1:0] SENSE_SELECT_IN,
  input wire logic OFFSTATE_SOURCE_ENABLE_IN,
  input wire logic EXT_DRIVER_COMPAT_BIT_IN,
  input wire logic STATUS_BIT5_IN,
  input wire logic STATUS_BIT7_IN,
  input wire logic [cdl_pkg::CDL_WORD_W-1:0] CHANNEL_FAULT_SUMMARY_OUT,
  input wire logic BYPASS_MONITOR_RESULT_OUT,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] SENSE_ROUTE_OUT,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] LATCH_OFF_OUT,
  input wire logic [cdl_pkg::CDL_NUM_CH-1:0] SOURCE_ENABLE_OUT,
  input wire logic EXT_DIAG_PIN0_OUT,
  input wire logic EXT_DIAG_PIN1_OUT
);
  default clocking dcb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  // quiet time since a latching cause; the synchroniser lets a late cause land after a clear
  logic [2:0] quiet_reg;
  logic [2:0] quiet_next;
  wire any_cause = |(OVERTEMP_IN | OVERCURRENT_IN | DYN_FINAL_IN);
  wire clr_cmd = CLEAR_LATCH_WR_IN && CLEAR_LATCH_CMD_IN;
  assign quiet_next = any_cause ? 3'h0 : ((quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1);
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      quiet_reg <= 3'h0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  bit6_zero_a: assert property (!CHANNEL_FAULT_SUMMARY_OUT[CDL_BIT_ZERO])
    else $error("word bit 6 not zero");
  status_pass_a: assert property ($stable({STATUS_BIT7_IN, STATUS_BIT5_IN}) && $past(NRST_IN)
    |=> {CHANNEL_FAULT_SUMMARY_OUT[CDL_BIT_STAT7], CHANNEL_FAULT_SUMMARY_OUT[CDL_BIT_STAT5]}
    == $past({STATUS_BIT7_IN, STATUS_BIT5_IN})) else $error("status bits not in word");
  route_onehot_a: assert property ($onehot0(SENSE_ROUTE_OUT))
    else $error("more than one sense route");
  route_off_a: assert property ((SENSE_ROUTE_OUT & ~$past(CHANNEL_ON_CMD_IN)
    & ~$past(CHANNEL_ON_CMD_IN, 2)) == '0) else $error("sense routed from an off channel");
  mux_off_a: assert property (SENSE_SELECT_IN[2] [*2] |=> SENSE_ROUTE_OUT == '0)
    else $error("sense routed while disabled");
  err_mask_a: assert property ((CHANNEL_FAULT_SUMMARY_OUT[CDL_ERR_MSB:CDL_ERR_LSB]
    & ~$past(CHANNEL_ON_CMD_IN) & ~$past(CHANNEL_ON_CMD_IN, 2)) == '0)
    else $error("error flag set on an off channel");
  clr_latch_a: assert property (clr_cmd && !any_cause && quiet_reg == 3'h7
    |-> ##2 LATCH_OFF_OUT == '0) else $error("clear command left a latch set");
  latch_hold_a: assert property (|($past(LATCH_OFF_OUT) & ~LATCH_OFF_OUT)
    |-> $past(clr_cmd, 2)) else $error("latch fell unasked");
  src_gate_a: assert property ((SOURCE_ENABLE_OUT & ($past(CHANNEL_ON_CMD_IN)
    | {CDL_NUM_CH{!$past(OFFSTATE_SOURCE_ENABLE_IN)}})) == '0)
    else $error("open-load source on without leave");
  ext_pin_a: assert property (EXT_DRIVER_COMPAT_BIT_IN && SENSE_SELECT_IN == CDL_SEL_EXT1
    |=> EXT_DIAG_PIN0_OUT && EXT_DIAG_PIN1_OUT) else $error("compat pins wrong");
  byp_off_a: assert property (SENSE_SELECT_IN[2] [*4] |=> !BYPASS_MONITOR_RESULT_OUT
    && !CHANNEL_FAULT_SUMMARY_OUT[CDL_BIT_BYPASS]) else $error("bypass set with no channel");
  clr_seen_c: cover property (clr_cmd && LATCH_OFF_OUT != '0);
  route_seen_c: cover property (SENSE_ROUTE_OUT != '0);
  latch_rise_c: cover property ($rose(|LATCH_OFF_OUT));
endmodule
bind cdl_top cdl_props #(.NUM_CH(NUM_CH)) u_cdl_props (
  .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .CHANNEL_ON_CMD_IN(CHANNEL_ON_CMD_IN),
  .OVERTEMP_IN(OVERTEMP_IN), .OVERCURRENT_IN(OVERCURRENT_IN), .DYN_FINAL_IN(DYN_FINAL_IN),
  .CLEAR_LATCH_WR_IN(CLEAR_LATCH_WR_IN), .CLEAR_LATCH_CMD_IN(CLEAR_LATCH_CMD_IN),
  .SENSE_SELECT_IN(SENSE_SELECT_IN), .OFFSTATE_SOURCE_ENABLE_IN(OFFSTATE_SOURCE_ENABLE_IN),
  .EXT_DRIVER_COMPAT_BIT_IN(EXT_DRIVER_COMPAT_BIT_IN), .STATUS_BIT5_IN(STATUS_BIT5_IN),
  .STATUS_BIT7_IN(STATUS_BIT7_IN), .CHANNEL_FAULT_SUMMARY_OUT(CHANNEL_FAULT_SUMMARY_OUT),
  .BYPASS_MONITOR_RESULT_OUT(BYPASS_MONITOR_RESULT_OUT), .SENSE_ROUTE_OUT(SENSE_ROUTE_OUT),
  .LATCH_OFF_OUT(LATCH_OFF_OUT), .SOURCE_ENABLE_OUT(SOURCE_ENABLE_OUT),
  .EXT_DIAG_PIN0_OUT(EXT_DIAG_PIN0_OUT), .EXT_DIAG_PIN1_OUT(EXT_DIAG_PIN1_OUT)
);

// ---- tb/channel_diagnosis_logic_bench.sv ----
// self-checking bench of the channel diagnosis logic
`timescale 1ns/1ps
module channel_diagnosis_logic_bench;
  import cdl_pkg::*;
  logic clk = 1'b0;
  logic nrst, sclk, cs_n, clr_wr, clr_cmd, offen, lvl, compat, st5, st7, byp, lvl_hi, pin0, pin1;
  logic [3:0] on_cmd, ot, oc, dynf, ovl, vds, route, latch, src;
  logic [1:0] ltype, led;
  logic [2:0] sel;
  logic [7:0] word, exp;
  logic [31:0] r;
  logic hit;
  int ch, fails, check_count, cycles;
  cdl_spi_master u_cdl_spi_master (.sclk_out(sclk), .cs_n_out(cs_n));
  cdl_top u_cdl_top (.SYS_CLK_IN(clk), .NRST_IN(nrst), .SCLK_IN(sclk), .SPI_CS_N_IN(cs_n),
    .CHANNEL_ON_CMD_IN(on_cmd), .OVERTEMP_IN(ot), .OVERCURRENT_IN(oc), .DYN_FINAL_IN(dynf),
    .OVERLOAD_MON_IN(ovl), .VDS_ABOVE_THR_IN(vds), .CLEAR_LATCH_WR_IN(clr_wr),
    .CLEAR_LATCH_CMD_IN(clr_cmd), .LOAD_TYPE_SELECT_IN(ltype), .SENSE_SELECT_IN(sel),
    .OFFSTATE_SOURCE_ENABLE_IN(offen), .SOURCE_LEVEL_SELECT_IN(lvl),
    .EXT_DRIVER_COMPAT_BIT_IN(compat), .STATUS_BIT5_IN(st5), .STATUS_BIT7_IN(st7),
    .CHANNEL_FAULT_SUMMARY_OUT(word), .BYPASS_MONITOR_RESULT_OUT(byp),
    .SENSE_ROUTE_OUT(route), .LATCH_OFF_OUT(latch), .SOURCE_ENABLE_OUT(src),
    .SOURCE_LEVEL_HIGH_OUT(lvl_hi), .LED_RATIO_OUT(led), .EXT_DIAG_PIN0_OUT(pin0),
    .EXT_DIAG_PIN1_OUT(pin1));
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  // hang guard, far above the thousand or so cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // bench inputs change just after a falling edge; the link master times select and serial clock itself
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame();
    u_cdl_spi_master.send_frame(3);
    cyc(8);
  endtask
  // expected external pins: compat mode turns them into enable and select
  function automatic logic [7:0] exp_pins(input logic [2:0] s, input logic c);
    exp_pins = c ? {6'h00, s == CDL_SEL_EXT1, s == CDL_SEL_EXT0 || s == CDL_SEL_EXT1}
      : {6'h00, s == CDL_SEL_EXT1, s == CDL_SEL_EXT0};
  endfunction
  function automatic logic [7:0] exp_route(input logic [2:0] s, input logic [3:0] on);
    exp_route = (!s[2] && on[s[1:0]]) ? 8'h01 << s[1:0] : 8'h00;
  endfunction
  function automatic logic [7:0] exp_src(input logic [2:0] s, input logic [3:0] on, input logic e);
    exp_src = (e && !s[2] && !on[s[1:0]]) ? 8'h01 << s[1:0] : 8'h00;
  endfunction
  function automatic logic exp_byp(input logic [2:0] s, input logic [3:0] v);
    exp_byp = !s[2] && v[s[1:0]];
  endfunction
  initial begin
    {nrst, clr_wr, clr_cmd, offen, lvl, compat, st5, st7} = 8'h00;
    {on_cmd, ot, oc, dynf, ovl, vds} = 24'h000000;
    ltype = 2'h0;
    sel = CDL_SEL_RST;
    r = $urandom(32'hFAAB0CD6);
    cyc(3);
    chk(word, CDL_WORD_RST);
    chk({route, latch}, 8'h00);
    chk({src, led, pin1, pin0}, 8'h00);
    nrst = 1'b1;
    cyc(3);
    // random settings; the first eight visit every sense-select code
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      {on_cmd, vds, sel, offen, lvl, compat, st5, st7, ltype} = r[17:0];
      if (i < 8) sel = 3'(i);
      cyc(6);
      chk(word & 8'hF0, {st7, 1'b0, st5, exp_byp(sel, vds), 4'h0});
      chk({7'h00, byp}, {7'h00, exp_byp(sel, vds)});
      chk({4'h0, route}, exp_route(sel, on_cmd));
      chk({4'h0, src}, exp_src(sel, on_cmd, offen));
      chk({5'h00, lvl_hi, led}, {5'h00, lvl, ltype});
      chk({6'h00, pin1, pin0}, exp_pins(sel, compat));
      chk({4'h0, word[3:0]}, 8'h00);
    end
    // overload pulse held until a frame, persistent overload sets again
    {sel, offen, vds, on_cmd} = {CDL_SEL_OFF, 1'b0, 4'h0, 4'hF};
    ovl = 4'h5;
    cyc(2);
    ovl = 4'h0;
    cyc(20);
    chk({4'h0, word[3:0]}, 8'h05);
    frame();
    chk({4'h0, word[3:0]}, 8'h00);
    ovl = 4'h2;
    cyc(8);
    frame();
    chk({4'h0, word[3:0]}, 8'h02);
    on_cmd = 4'hD;
    cyc(4);
    chk({4'h0, word[3:0]}, 8'h00);
    ovl = 4'h0;
    on_cmd = 4'hF;
    cyc(4);
    frame();
    // over-current on every channel, over-temperature on 0 and 3, final dynamic on 2
    for (int j = 0; j < 7; j++) begin
      ch = (j < 4) ? j : ((j == 4) ? 0 : 8 - j);
      hit = (j > 3) || (ch < 2);
      sel = 3'(ch);
      if (j < 4) oc = 4'h1 << ch;
      else if (j < 6) ot = 4'h1 << ch;
      else dynf = 4'h1 << ch;
      cyc(2);
      oc = 4'h0;
      ot = 4'h0;
      dynf = 4'h0;
      cyc(8);
      exp = hit ? 8'h01 << ch : 8'h00;
      chk({4'h0, latch}, exp);
      chk({4'h0, word[3:0]}, exp);
      chk({4'h0, route}, hit ? 8'h00 : 8'h01 << ch);
      frame();
      chk({4'h0, word[3:0]}, exp);
      clr_wr = 1'b1;
      cyc(1);
      clr_wr = 1'b0;
      cyc(3);
      chk({4'h0, latch}, exp);
      {clr_wr, clr_cmd} = 2'h3;
      cyc(1);
      {clr_wr, clr_cmd} = 2'h0;
      cyc(2);
      chk({4'h0, latch}, 8'h00);
      chk({4'h0, word[3:0]}, exp);
      frame();
      chk({4'h0, word[3:0]}, 8'h00);
    end
    complete_run();
  end
endmodule
